// *** foc_pkg.sv ***
// package: register map, field layout, operation codes and timing for the flash operation control block
package foc_pkg;
    localparam int FOC_AW = 4;
    localparam int FOC_DW = 16;
    // register addresses
    localparam logic [3:0] FOC_ADDR_CTRL = 4'h0;
    localparam logic [3:0] FOC_ADDR_KEY = 4'h1;
    localparam logic [3:0] FOC_ADDR_STAT = 4'h2;
    localparam logic [3:0] FOC_ADDR_IEN = 4'h3;
    localparam logic [3:0] FOC_ADDR_ICLR = 4'h4;
    // control register fields
    localparam int FOC_BIT_START = 15;
    localparam int FOC_BIT_ENABLE = 14;
    localparam int FOC_BIT_FAULT = 13;
    localparam int FOC_BIT_ERASE = 6;
    localparam int FOC_OP_LSB = 0;
    localparam logic [15:0] FOC_CTRL_RESET = 16'h0000;
    // unlock keys
    localparam logic [7:0] FOC_KEY_FIRST = 8'h55;
    localparam logic [7:0] FOC_KEY_SECOND = 8'haa;
    // operation selector codes with erase mode set
    localparam logic [3:0] FOC_OP_BULK = 4'hf;
    localparam logic [3:0] FOC_OP_GENSEG = 4'hd;
    localparam logic [3:0] FOC_OP_SECSEG = 4'hc;
    localparam logic [3:0] FOC_OP_PAGE = 4'h2;
    localparam logic [3:0] FOC_OP_CFGBYTE = 4'h0;
    // operation selector codes with erase mode clear
    localparam logic [3:0] FOC_OP_WORD = 4'h3;
    localparam logic [3:0] FOC_OP_ROW = 4'h1;
    // interrupt status bits
    localparam int FOC_IRQ_DONE = 0;
    localparam int FOC_IRQ_FAULT = 1;
    localparam int FOC_IRQ_W = 2;
    // operation duration
    localparam int FOC_CLK_MHZ = 25;
    localparam int FOC_OP_TIME_US = 1500;
    localparam int FOC_OP_CYCLES = FOC_OP_TIME_US * FOC_CLK_MHZ;
    // register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [15:0] wdata;
    } foc_bus_t;
    typedef enum logic [2:0] {
        FOC_IDLE = 3'b001,
        FOC_ARMED = 3'b010,
        FOC_BUSY = 3'b100
    } foc_state_t;
endpackage

// *** foc_tb_top.sv ***
// testbench: register-level tests of the flash operation control block
`timescale 1ns/1ps
`default_nettype none
module foc_tb_top import foc_pkg::*;;
    localparam int TB_OP = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic irq_en = 1'b0;
    logic [15:0] rdata;
    logic busy;
    logic [4:0] op;
    logic irq;
    int miscompares = 0;
    int checks_done = 0;
    logic [15:0] good_ops [8] = '{16'hc04f, 16'hc04d, 16'hc04c, 16'hc042, 16'hc040, 16'hc003, 16'hc001, 16'hc000};
    logic [15:0] bad_ops [6] = '{16'hc04e, 16'hc04b, 16'hc041, 16'hc043, 16'hc00f, 16'hc002};
    foc_top #(.OP_CYCLES(TB_OP)) uut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .BUSY_OUT(busy), .OP_OUT(op), .IRQ_OUT(irq));
    // 25 MHz system clock
    always #20 clk = ~clk;
    // compare and count, report a mismatch at once
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one write cycle; the strobe stays up so writes can follow back to back
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        rd <= 1'b0;
        wr <= 1'b1;
        @(posedge clk);
    endtask
    // drop both strobes for n cycles
    task automatic bus_idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    // one read cycle; data are taken at the edge that closes the cycle after the strobe
    task automatic bus_rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] mask, input string what);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        check(rdata & mask, exp, what);
    endtask
    // unlock (0 none, 1 proper, 2 broken by a stray key, 3 spent by a ctrl write), start, judge outcome
    task automatic run_op(input logic [15:0] ctrl, input int unlock, input logic ok);
        int n;
        n = 0;
        if (unlock != 0) bus_wr(FOC_ADDR_KEY, 16'h0055);
        if (unlock == 2) bus_wr(FOC_ADDR_KEY, 16'h0012);
        if (unlock != 0) bus_wr(FOC_ADDR_KEY, 16'h00aa);
        if (unlock == 3) bus_wr(FOC_ADDR_CTRL, ctrl & 16'h7fff);
        bus_wr(FOC_ADDR_CTRL, ctrl);
        bus_idle(1);
        check(16'(busy), 16'(ok), "busy after start");
        if (ok) begin
            check(16'(op), 16'({ctrl[6], ctrl[3:0]}), "selected operation");
            while (busy === 1'b1 && n < TB_OP + 4) begin
                @(posedge clk);
                n++;
            end
            check(16'(busy), 16'h0000, "busy cleared by hardware");
            check(16'(n), 16'(TB_OP), "operation length");
            bus_rd(FOC_ADDR_CTRL, ctrl & 16'h404f, 16'hffff, "ctrl after completion");
            bus_rd(FOC_ADDR_STAT, 16'h0001, 16'h0001, "done status");
        end else begin
            bus_rd(FOC_ADDR_CTRL, 16'h2000, 16'ha000, "ctrl after refused start");
            bus_rd(FOC_ADDR_STAT, 16'h0002, 16'h0002, "fault status");
        end
        check(16'(irq), 16'(irq_en), "interrupt level");
        bus_wr(FOC_ADDR_ICLR, 16'h0003);
        bus_idle(2);
        check(16'(irq), 16'h0000, "interrupt after clear");
        bus_rd(FOC_ADDR_STAT, 16'h0000, 16'h0003, "status after clear");
    endtask
    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // main test sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus_rd(FOC_ADDR_CTRL, FOC_CTRL_RESET, 16'hffff, "ctrl reset value");
        check(16'({irq, busy, op}), 16'h0000, "outputs after reset");
        bus_wr(4'h7, 16'hffff);
        bus_rd(4'h7, 16'h0000, 16'hffff, "unmapped read");
        bus_rd(FOC_ADDR_CTRL, 16'h0000, 16'hffff, "ctrl after unmapped write");
        bus_wr(FOC_ADDR_IEN, 16'h0003);
        irq_en = 1'b1;
        foreach (good_ops[i]) run_op(good_ops[i], 1, 1'b1);
        foreach (bad_ops[i]) run_op(bad_ops[i], 1, 1'b0);
        run_op(16'hc042, 0, 1'b0);
        run_op(16'hc042, 2, 1'b0);
        run_op(16'hc042, 3, 1'b0);
        run_op(16'h8042, 1, 1'b0);
        run_op(16'hc042, 1, 1'b1);
        // a running erase ignores a control write, then aborts when the enable bit clears
        bus_wr(FOC_ADDR_KEY, 16'h0055);
        bus_wr(FOC_ADDR_KEY, 16'h00aa);
        bus_wr(FOC_ADDR_CTRL, 16'hc042);
        bus_wr(FOC_ADDR_CTRL, 16'hc04f);
        bus_wr(FOC_ADDR_CTRL, 16'h0042);
        bus_idle(2);
        check(16'(busy), 16'h0000, "busy after abort");
        check(16'(op), 16'h0012, "selection held while running");
        bus_rd(FOC_ADDR_CTRL, 16'h2000, 16'ha000, "fault after abort");
        bus_rd(FOC_ADDR_STAT, 16'h0002, 16'h0002, "fault status after abort");
        // masked interrupt stays low
        bus_wr(FOC_ADDR_IEN, 16'h0000);
        irq_en = 1'b0;
        run_op(16'hc001, 1, 1'b1);
        conclude();
    end
    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
endmodule
`default_nettype wire

// *** foc_top.sv ***
// flash operation control: control register, key unlock, operation timer and interrupt
// Contract
// - erase mode, selector 1111: bulk erase
// - erase mode, selector 1101: general segment erase
// - erase mode, selector 0000: configuration byte erase
// - unimplemented selector codes never run
`timescale 1ns/1ps
`default_nettype none
module foc_top import foc_pkg::*; #(
    parameter int OP_CYCLES = FOC_OP_CYCLES
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [15:0] RDATA_OUT,
    output logic BUSY_OUT,
    output logic [4:0] OP_OUT,
    output logic IRQ_OUT
);
    localparam logic [31:0] OP_LAST = 32'(OP_CYCLES - 1);

    // legal operation for the erase mode and selector
    function automatic logic op_valid(input logic erase, input logic [3:0] op);
        if (erase) begin
            op_valid = (op == FOC_OP_BULK) || (op == FOC_OP_GENSEG) || (op == FOC_OP_SECSEG) ||
                       (op == FOC_OP_PAGE) || (op == FOC_OP_CFGBYTE);
        end else begin
            op_valid = (op == FOC_OP_WORD) || (op == FOC_OP_ROW) || (op == FOC_OP_CFGBYTE);
        end
    endfunction

    // bus request gathered into one carrier
    foc_bus_t bus;
    assign bus = '{wr: WR_IN, rd: RD_IN, addr: ADDR_IN, wdata: WDATA_IN};

    foc_state_t state, next_state;
    logic start, next_start;
    logic enable, next_enable;
    logic fault, next_fault;
    logic erase, next_erase;
    logic [3:0] op, next_op;
    logic key_first, next_key_first;
    logic [31:0] cnt, next_cnt;
    logic [FOC_IRQ_W-1:0] ist, next_ist;
    logic [FOC_IRQ_W-1:0] ien, next_ien;
    logic [15:0] rdata, next_rdata;
    logic busy, next_busy;
    logic [4:0] op_o, next_op_o;
    logic irq, next_irq;
    logic [15:0] ctrl_view;
    logic wr_ctrl, wr_key, set_start, done, bad;

    // register view, write decode and completion strobe
    assign ctrl_view = {start, enable, fault, 6'h00, erase, 2'h0, op};
    assign wr_ctrl = bus.wr && (bus.addr == FOC_ADDR_CTRL);
    assign wr_key = bus.wr && (bus.addr == FOC_ADDR_KEY);
    assign set_start = wr_ctrl && bus.wdata[FOC_BIT_START] && !start;
    assign done = (state == FOC_BUSY) && (cnt == OP_LAST);

    // sequencer, key tracking and control fields
    always_comb begin
        next_state = state;
        next_start = start;
        next_enable = enable;
        next_fault = fault;
        next_erase = erase;
        next_op = op;
        next_key_first = key_first;
        next_cnt = cnt;
        bad = 1'b0;
        if (bus.wr) begin
            next_key_first = 1'b0; // any other write breaks the key pair
        end
        unique case (state)
            FOC_IDLE: begin
                if (wr_key && bus.wdata[7:0] == FOC_KEY_FIRST) begin
                    next_key_first = 1'b1;
                end else if (wr_key && key_first && bus.wdata[7:0] == FOC_KEY_SECOND) begin
                    next_state = FOC_ARMED;
                end
                if (wr_ctrl) begin
                    next_enable = bus.wdata[FOC_BIT_ENABLE];
                    next_erase = bus.wdata[FOC_BIT_ERASE];
                    next_op = bus.wdata[3:0];
                    if (!bus.wdata[FOC_BIT_FAULT]) begin
                        next_fault = 1'b0;
                    end
                    if (set_start) begin
                        bad = 1'b1; // start without unlock
                    end
                end
            end
            FOC_ARMED: begin
                if (wr_ctrl) begin
                    next_enable = bus.wdata[FOC_BIT_ENABLE];
                    next_erase = bus.wdata[FOC_BIT_ERASE];
                    next_op = bus.wdata[3:0];
                    next_state = FOC_IDLE; // unlock is used up by any control write
                    if (set_start) begin
                        if (bus.wdata[FOC_BIT_ENABLE] &&
                            op_valid(bus.wdata[FOC_BIT_ERASE], bus.wdata[3:0])) begin
                            next_start = 1'b1;
                            next_cnt = 32'h0;
                            next_state = FOC_BUSY;
                        end else begin
                            bad = 1'b1;
                        end
                    end
                end else if (bus.wr) begin
                    next_state = FOC_IDLE;
                end
            end
            FOC_BUSY: begin
                // control writes are ignored while the operation runs, except one that clears the enable bit, which aborts it
                if (wr_ctrl && !bus.wdata[FOC_BIT_ENABLE]) begin
                    next_enable = 1'b0;
                    next_start = 1'b0;
                    next_state = FOC_IDLE;
                    bad = 1'b1; // early termination
                end else if (done) begin
                    next_start = 1'b0;
                    next_fault = 1'b0;
                    next_state = FOC_IDLE;
                end else begin
                    next_cnt = cnt + 32'h1;
                end
            end
            default: begin
                next_state = FOC_IDLE;
            end
        endcase
        if (bad) begin
            next_fault = 1'b1;
            next_start = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state <= FOC_IDLE;
            start <= 1'b0;
            enable <= 1'b0;
            fault <= 1'b0;
            erase <= 1'b0;
            op <= 4'h0;
            key_first <= 1'b0;
            cnt <= 32'h0;
        end else begin
            state <= next_state;
            start <= next_start;
            enable <= next_enable;
            fault <= next_fault;
            erase <= next_erase;
            op <= next_op;
            key_first <= next_key_first;
            cnt <= next_cnt;
        end
    end

    // interrupt status, enable, read data and outputs
    always_comb begin
        next_ist = ist;
        next_ien = ien;
        if (bus.wr && bus.addr == FOC_ADDR_ICLR) begin
            next_ist = ist & ~bus.wdata[FOC_IRQ_W-1:0];
        end
        if (bus.wr && bus.addr == FOC_ADDR_IEN) begin
            next_ien = bus.wdata[FOC_IRQ_W-1:0];
        end
        if (done && !(wr_ctrl && !bus.wdata[FOC_BIT_ENABLE])) begin
            next_ist[FOC_IRQ_DONE] = 1'b1; // set wins over clear
        end
        if (bad) begin
            next_ist[FOC_IRQ_FAULT] = 1'b1;
        end
        next_rdata = 16'h0000;
        if (bus.rd) begin
            unique case (bus.addr)
                FOC_ADDR_CTRL: next_rdata = ctrl_view;
                FOC_ADDR_STAT: next_rdata = {14'h0000, ist};
                FOC_ADDR_IEN: next_rdata = {14'h0000, ien};
                default: next_rdata = 16'h0000;
            endcase
        end
        next_busy = next_start;
        next_op_o = {next_erase, next_op};
        next_irq = |(next_ist & next_ien);
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ist <= '0;
            ien <= '0;
            rdata <= 16'h0000;
            busy <= 1'b0;
            op_o <= 5'h00;
            irq <= 1'b0;
        end else begin
            ist <= next_ist;
            ien <= next_ien;
            rdata <= next_rdata;
            busy <= next_busy;
            op_o <= next_op_o;
            irq <= next_irq;
        end
    end

    // outputs come straight from their flip-flops
    assign RDATA_OUT = rdata;
    assign BUSY_OUT = busy;
    assign OP_OUT = op_o;
    assign IRQ_OUT = irq;

    // reference count of the cycles that the start bit stays high, kept apart from the sequencer counter
    logic [31:0] run_len, next_run_len;
    always_comb begin
        next_run_len = 32'h0;
        if (start) begin
            next_run_len = run_len + 32'h1;
        end
    end

    // the reference count is only read by the run length check
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            run_len <= 32'h0;
        end else begin
            run_len <= next_run_len;
        end
    end

    // checks
    a_start_needs_unlock: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        $rose(start) |-> $past(state) == FOC_ARMED) else $error("start set without unlock");
    a_bad_op_rejected: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        $rose(start) |-> op_valid(erase, op)) else $error("unimplemented operation started");
    a_start_clears: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        done |=> !start && state == FOC_IDLE) else $error("start not cleared at completion");
    a_fault_on_success: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        done && !bad |=> !fault) else $error("fault not cleared on success");
    a_fault_on_bad: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        bad |=> fault && !start) else $error("fault not set on improper sequence");
    a_bulk_runs: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        state == FOC_ARMED && set_start && bus.wdata[FOC_BIT_ENABLE] && bus.wdata[FOC_BIT_ERASE]
        && bus.wdata[3:0] == FOC_OP_BULK |=> start) else $error("bulk erase not started");
    a_genseg_runs: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        state == FOC_ARMED && set_start && bus.wdata[FOC_BIT_ENABLE] && bus.wdata[FOC_BIT_ERASE]
        && bus.wdata[3:0] == FOC_OP_GENSEG |=> start) else $error("segment erase not started");
    a_cfg_runs: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        state == FOC_ARMED && set_start && bus.wdata[FOC_BIT_ENABLE] && bus.wdata[FOC_BIT_ERASE]
        && bus.wdata[3:0] == FOC_OP_CFGBYTE |=> start) else $error("config erase not started");
    a_busy_follows: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        BUSY_OUT == start) else $error("busy output wrong");
    c_page_erase: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        $rose(start) && erase && op == FOC_OP_PAGE);
    c_row_prog: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        $rose(start) && !erase && op == FOC_OP_ROW);
    c_done: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) done);
    c_fault: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) bad);
    c_abort: cover property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN) state == FOC_BUSY && bad);

    // an unlock is spent by the next write, and a control write during a run aborts it only when it clears the enable bit
    a_armed_spent: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        state == FOC_ARMED && bus.wr |=> state != FOC_ARMED) else $error("unlock not spent by a write");
    a_ctrl_ignored: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        state == FOC_BUSY && wr_ctrl && bus.wdata[FOC_BIT_ENABLE] && !done
        |=> start && state == FOC_BUSY) else $error("control write disturbed a running operation");

    // refused starts leave the sequencer idle with the fault flag up
    a_unimpl_refused: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        state == FOC_ARMED && set_start && !op_valid(bus.wdata[FOC_BIT_ERASE], bus.wdata[3:0])
        |=> !start && fault && state == FOC_IDLE) else $error("unimplemented operation not refused");
    a_locked_refused: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        state == FOC_IDLE && set_start |=> !start && fault) else $error("locked start not refused");

    // a running operation holds its selection and its count stays in range
    a_op_held: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        state == FOC_BUSY |=> $stable(op) && $stable(erase)) else $error("selection changed while running");
    a_count_bound: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        state == FOC_BUSY |-> cnt <= OP_LAST) else $error("operation counter out of range");
    a_busy_running: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        BUSY_OUT == (state == FOC_BUSY)) else $error("busy output disagrees with sequencer");

    // an operation that ends normally has run for exactly the programmed number of cycles
    a_run_length: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        $fell(start) && !fault |-> run_len == 32'(OP_CYCLES)) else $error("operation length wrong");

    // completion and refusal are reported in the sticky status
    a_done_status: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        done && !bad |=> ist[FOC_IRQ_DONE]) else $error("done status not set");
    a_fault_status: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        bad |=> ist[FOC_IRQ_FAULT]) else $error("fault status not set");
    a_irq_level: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        IRQ_OUT == |(ist & ien)) else $error("interrupt level wrong");

    // read data stand only in the cycle after a read strobe
    a_rdata_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
        !RD_IN |=> RDATA_OUT == 16'h0000) else $error("read data outside a read cycle");
endmodule
`default_nettype wire
